// ==== power_state_consts.svh ====
// timing counts and reset values for the module power state manager
// assumes a 100 MHz clk_in
`ifndef POWER_STATE_CONSTS_SVH
`define POWER_STATE_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define MIN_PULSE_MS 16
`define MIN_PULSE_CYCLES ((`MIN_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define DEBOUNCE_RESET_CYCLES 1000
`define CARRIER_RESET_US 1
`define CARRIER_RESET_CYCLES ((`CARRIER_RESET_US * 1000) / `CLK_PERIOD_NS)
`define SUSPEND_WARN_US 1
`define SUSPEND_WARN_CYCLES ((`SUSPEND_WARN_US * 1000) / `CLK_PERIOD_NS)
`define NUM_EVENT_INPUTS 10
`define EV_POWER 0
`define EV_RESET 1
`define EV_SUPPLY 2
`define EV_PCIE_WAKE 3
`define EV_GEN_WAKE 4
`define EV_BATTERY 5
`define EV_OVERTEMP 6
`define EV_ALERT 7
`define EV_LID 8
`define EV_SLEEP 9
`endif

// ==== power_state_pkg.sv ====
// types shared by the module power state manager
// no assumptions beyond a SystemVerilog tool
`default_nettype none
package power_state_pkg;
   typedef enum logic [3:0] {
      ST_SOFT_OFF = 4'b0001,
      ST_ON = 4'b0010,
      ST_WARN = 4'b0100,
      ST_RAM_SUSPEND = 4'b1000
   } power_state_t;
endpackage
`default_nettype wire

// ==== power_state_manager.sv ====
// power and system management logic of the module: buttons, wakes, resets, sleep states
// assumes one 100 MHz clock; pins are asynchronous and synchronised here, except primary_supply_low_in, which feeds reset directly
`include "power_state_consts.svh"
`default_nettype none

module power_state_manager
   import power_state_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = `MIN_PULSE_CYCLES,
   parameter int RESET_PULSE_CYCLES = `CARRIER_RESET_CYCLES,
   parameter int WARN_CYCLES = `SUSPEND_WARN_CYCLES
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   // carrier pins, asynchronous
   input wire logic power_button_n_in,
   input wire logic reset_button_n_in,
   input wire logic supply_good_in,
   input wire logic primary_supply_low_in,
   input wire logic pcie_wake_n_in,
   input wire logic general_wake_n_in,
   input wire logic battery_low_n_in,
   input wire logic overtemp_in_n_in,
   input wire logic smbus_alert_n_in,
   input wire logic lid_n_in,
   input wire logic sleep_button_n_in,
   // on-module sources, same clock
   input wire logic watchdog_timeout_in,
   input wire logic soft_reset_req_in,
   input wire logic suspend_req_in,
   input wire logic soft_off_req_in,
   input wire logic cpu_shutdown_in,
   // smbus pins, split into in, out and enable
   input wire logic smbus_clock_in,
   input wire logic smbus_data_in,
   output logic smbus_clock_out,
   output logic smbus_clock_oe_out,
   output logic smbus_data_out,
   output logic smbus_data_oe_out,
   input wire logic smbus_clock_drive_low_in,
   input wire logic smbus_data_drive_low_in,
   output logic smbus_clock_sense_out,
   output logic smbus_data_sense_out,
   // carrier outputs
   output logic carrier_reset_n_out,
   output logic suspend_pending_n_out,
   output logic ram_suspend_n_out,
   output logic disk_suspend_n_out,
   output logic soft_off_n_out,
   output logic cpu_trip_n_out,
   // events to power-management software: one-cycle pulses, plus overtemp, lid closed and running levels
   output logic wake_event_out,
   output logic smi_event_out,
   output logic battery_low_event_out,
   output logic overtemp_out,
   output logic lid_closed_out,
   output logic lid_event_out,
   output logic sleep_button_event_out,
   output logic system_running_out
);

   localparam int NEV = `NUM_EVENT_INPUTS;
   localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int RW = $clog2(RESET_PULSE_CYCLES + 1);
   localparam int WW = $clog2(WARN_CYCLES + 1);

   logic [NEV-1:0] raw_active;
   logic [NEV-1:0] sync1_reg;
   logic [NEV-1:0] sync2_reg;
   logic [NEV-1:0] clean_reg;
   logic [NEV-1:0] clean_prev_reg;
   logic [NEV-1:0] rise;
   logic [NEV-1:0] fall;
   logic [DW-1:0] db_cnt_reg [NEV];
   logic [1:0] smb_sync1_reg;
   logic [1:0] smb_sync2_reg;
   power_state_t state_reg;
   logic [RW-1:0] rst_cnt_reg;
   logic [WW-1:0] warn_cnt_reg;
   logic trip_reg;
   logic wake_any;
   logic reset_cause;

   // inputs mapped to active-high sense
   always_comb begin
      raw_active = '0;
      raw_active[`EV_POWER] = ~power_button_n_in;
      raw_active[`EV_RESET] = ~reset_button_n_in;
      raw_active[`EV_SUPPLY] = supply_good_in;
      raw_active[`EV_PCIE_WAKE] = ~pcie_wake_n_in;
      raw_active[`EV_GEN_WAKE] = ~general_wake_n_in;
      raw_active[`EV_BATTERY] = ~battery_low_n_in;
      raw_active[`EV_OVERTEMP] = ~overtemp_in_n_in;
      raw_active[`EV_ALERT] = ~smbus_alert_n_in;
      raw_active[`EV_LID] = ~lid_n_in;
      raw_active[`EV_SLEEP] = ~sleep_button_n_in;
   end

   // two-flop synchronisers; pull-ups make idle levels inactive
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         smb_sync1_reg <= 2'h3;
         smb_sync2_reg <= 2'h3;
      end else if (clk_en_in) begin
         sync1_reg <= raw_active;
         sync2_reg <= sync1_reg;
         smb_sync1_reg <= {smbus_clock_in, smbus_data_in};
         smb_sync2_reg <= smb_sync1_reg;
      end
   end

   // debounce: level accepted after it stays stable for the interval
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clean_reg <= '0;
         clean_prev_reg <= '0;
         for (int i = 0; i < NEV; i++) begin
            db_cnt_reg[i] <= '0;
         end
      end else if (clk_en_in) begin
         clean_prev_reg <= clean_reg;
         for (int i = 0; i < NEV; i++) begin
            if (sync2_reg[i] == clean_reg[i]) begin
               db_cnt_reg[i] <= '0;
            end else if (db_cnt_reg[i] == DW'(DEBOUNCE_CYCLES - 1)) begin
               clean_reg[i] <= sync2_reg[i];
               db_cnt_reg[i] <= '0;
            end else begin
               db_cnt_reg[i] <= db_cnt_reg[i] + 1'b1;
            end
         end
      end
   end

   assign rise = clean_reg & ~clean_prev_reg;
   assign fall = ~clean_reg & clean_prev_reg;
   assign wake_any = rise[`EV_POWER] | rise[`EV_PCIE_WAKE] | rise[`EV_GEN_WAKE]
      | rise[`EV_ALERT] | rise[`EV_SLEEP];

   // released button after press is the rising edge of the pin
   // power state machine
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= ST_SOFT_OFF;
         warn_cnt_reg <= '0;
      end else if (clk_en_in) begin
         unique case (state_reg)
            ST_SOFT_OFF: begin
               if (fall[`EV_POWER]) begin
                  state_reg <= ST_ON;
               end
            end
            ST_ON: begin
               if (soft_off_req_in || trip_reg) begin
                  state_reg <= ST_SOFT_OFF;
               end else if (suspend_req_in || rise[`EV_SLEEP]) begin
                  state_reg <= ST_WARN;
                  warn_cnt_reg <= WW'(WARN_CYCLES - 1);
               end
            end
            ST_WARN: begin
               if (warn_cnt_reg == '0) begin
                  state_reg <= ST_RAM_SUSPEND;
               end else begin
                  warn_cnt_reg <= warn_cnt_reg - 1'b1;
               end
            end
            ST_RAM_SUSPEND: begin
               if (wake_any) begin
                  state_reg <= ST_ON;
               end
            end
         endcase
      end
   end

   // reset causes; the button contributes only its edge
   assign reset_cause = rise[`EV_RESET] | ~clean_reg[`EV_SUPPLY] | primary_supply_low_in
      | watchdog_timeout_in | soft_reset_req_in;

   // carrier reset pulse stretcher
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_cnt_reg <= RW'(RESET_PULSE_CYCLES);
      end else if (clk_en_in) begin
         if (reset_cause || state_reg != ST_ON) begin
            rst_cnt_reg <= RW'(RESET_PULSE_CYCLES);
         end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
         end
      end
   end

   // thermal trip latch, cleared on power-up from soft-off
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trip_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (cpu_shutdown_in) begin
            trip_reg <= 1'b1;
         end else if (state_reg == ST_SOFT_OFF && fall[`EV_POWER]) begin
            trip_reg <= 1'b0;
         end
      end
   end

   // registered pin outputs and software events
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         carrier_reset_n_out <= 1'b0;
         suspend_pending_n_out <= 1'b1;
         ram_suspend_n_out <= 1'b1;
         soft_off_n_out <= 1'b0;
         cpu_trip_n_out <= 1'b1;
         wake_event_out <= 1'b0;
         smi_event_out <= 1'b0;
         battery_low_event_out <= 1'b0;
         overtemp_out <= 1'b0;
         lid_closed_out <= 1'b0;
         lid_event_out <= 1'b0;
         sleep_button_event_out <= 1'b0;
         system_running_out <= 1'b0;
      end else if (clk_en_in) begin
         carrier_reset_n_out <= (rst_cnt_reg == '0) && !reset_cause;
         suspend_pending_n_out <= !(state_reg == ST_WARN || state_reg == ST_RAM_SUSPEND);
         ram_suspend_n_out <= (state_reg != ST_RAM_SUSPEND);
         soft_off_n_out <= (state_reg != ST_SOFT_OFF);
         cpu_trip_n_out <= !trip_reg;
         wake_event_out <= (state_reg == ST_RAM_SUSPEND) && wake_any;
         smi_event_out <= rise[`EV_ALERT];
         battery_low_event_out <= rise[`EV_BATTERY];
         overtemp_out <= clean_reg[`EV_OVERTEMP];
         lid_closed_out <= clean_reg[`EV_LID];
         lid_event_out <= rise[`EV_LID] | fall[`EV_LID];
         sleep_button_event_out <= rise[`EV_SLEEP];
         system_running_out <= (state_reg == ST_ON);
      end
   end

   // disk suspend is unsupported: held inactive
   assign disk_suspend_n_out = 1'b1;

   // smbus open-drain pins: only drive low, enable while pulling
   assign smbus_clock_out = 1'b0;
   assign smbus_data_out = 1'b0;
   assign smbus_clock_oe_out = smbus_clock_drive_low_in;
   assign smbus_data_oe_out = smbus_data_drive_low_in;
   assign smbus_clock_sense_out = smb_sync2_reg[1];
   assign smbus_data_sense_out = smb_sync2_reg[0];

endmodule // power_state_manager
`default_nettype wire

// ==== power_state_manager_props.sv ====
// assertions on the power state manager ports
// one clock domain; bound to every instance
`default_nettype none
module psm_props (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic supply_good_in,
   input wire logic primary_supply_low_in,
   input wire logic reset_button_n_in,
   input wire logic watchdog_timeout_in,
   input wire logic soft_reset_req_in,
   input wire logic cpu_shutdown_in,
   input wire logic smbus_clock_drive_low_in,
   input wire logic smbus_clock_oe_out,
   input wire logic carrier_reset_n_out,
   input wire logic suspend_pending_n_out,
   input wire logic ram_suspend_n_out,
   input wire logic disk_suspend_n_out,
   input wire logic cpu_trip_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   AST_DISK_IDLE:
      assert property (disk_suspend_n_out) else $error("disk");
   AST_SMB_OE:
      assert property (smbus_clock_oe_out == smbus_clock_drive_low_in) else $error("oe");
   AST_PEND_RAM:
      assert property (!ram_suspend_n_out |-> !suspend_pending_n_out) else $error("pend");
   AST_WARN_FIRST:
      assert property ($fell(ram_suspend_n_out) |-> $past(suspend_pending_n_out, 3) == 1'b0)
      else $error("warn");
   AST_SUPPLY:
      assert property ($fell(supply_good_in) ##1 !supply_good_in [*8] ##1 !supply_good_in [*8]
      |-> !carrier_reset_n_out) else $error("supply");
   AST_FAST_RESET:
      assert property (primary_supply_low_in || watchdog_timeout_in || soft_reset_req_in
      |-> ##[0:2] !carrier_reset_n_out) else $error("cause");
   AST_HELD_RESET:
      assert property ($fell(carrier_reset_n_out) && !reset_button_n_in && supply_good_in
      |-> ##[1:12] carrier_reset_n_out) else $error("held");
   AST_TRIP:
      assert property ($fell(cpu_trip_n_out) |-> $past(cpu_shutdown_in) || $past(cpu_shutdown_in, 2))
      else $error("trip");
   // main scenarios reached
   cover property ($fell(ram_suspend_n_out));
   cover property ($fell(cpu_trip_n_out));
   cover property ($rose(carrier_reset_n_out));
endmodule // psm_props
bind power_state_manager psm_props props_i (.*);
`default_nettype wire

// ==== carrier_model.sv ====
// carrier board model: buttons and smbus pull-ups
// bench asks for presses on want_n_in, same clock
`default_nettype none
module carrier_model #(parameter int HOLD = 12) (
   input wire logic clk_in,
   input wire logic [8:0] want_n_in,
   input wire logic [1:0] dev_oe_in,
   input wire logic [1:0] car_low_in,
   output logic [8:0] pin_n_out,
   output logic [1:0] smb_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] pins = '1;
   int left [9] = '{default: 0};
   assign pin_n_out = pins;
   // open-drain lines, pulled high when released
   assign smb_out = ~(dev_oe_in | car_low_in);
   // a press stays low at least HOLD clocks
   always_ff @(posedge clk_in)
      for (int i = 0; i < 9; i++) begin
         if (!want_n_in[i])
            pins[i] <= 1'b0;
         else if (left[i] <= 1)
            pins[i] <= 1'b1;
         if (pins[i] && !want_n_in[i])
            left[i] <= HOLD;
         else if (left[i] > 0)
            left[i] <= left[i] - 1;
      end
endmodule // carrier_model
`default_nettype wire

// ==== power_state_manager_tb.sv ====
// bench for power_state_manager with the carrier model
// short debounce, pulse and warn counts
`default_nettype none
module power_state_manager_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, resetn_in = 0, clk_en_in = 1, supply_good_in = 1;
   logic primary_supply_low_in = 0, watchdog_timeout_in = 0, soft_reset_req_in = 0;
   logic suspend_req_in = 0, soft_off_req_in = 0, cpu_shutdown_in = 0;
   logic smbus_clock_in, smbus_data_in, smbus_clock_drive_low_in = 0;
   logic smbus_data_drive_low_in = 0, smbus_clock_out, smbus_clock_oe_out, smbus_data_out;
   logic smbus_data_oe_out, smbus_clock_sense_out, smbus_data_sense_out, carrier_reset_n_out;
   logic suspend_pending_n_out, ram_suspend_n_out, disk_suspend_n_out, soft_off_n_out;
   logic cpu_trip_n_out, wake_event_out, smi_event_out, battery_low_event_out, overtemp_out;
   logic lid_closed_out, lid_event_out, sleep_button_event_out, system_running_out;
   logic [8:0] want_n = '1, pin_n;
   logic [1:0] car_low = 0;
   logic [15:0] rnd = 16'h6911;
   logic [3:0] pat [4] = '{4'h9, 4'h5, 4'h3, 4'h0};
   int wk [4] = '{2, 3, 6, 8};
   int seen [6], mismatches, num_checks, cyc, b;
   wire [5:0] ev = {!carrier_reset_n_out, sleep_button_event_out, lid_event_out,
      battery_low_event_out, smi_event_out, wake_event_out};
   power_state_manager #(.DEBOUNCE_CYCLES(8), .RESET_PULSE_CYCLES(4), .WARN_CYCLES(4)) uut (
      .power_button_n_in(pin_n[0]), .reset_button_n_in(pin_n[1]), .pcie_wake_n_in(pin_n[2]),
      .general_wake_n_in(pin_n[3]), .battery_low_n_in(pin_n[4]), .overtemp_in_n_in(pin_n[5]),
      .smbus_alert_n_in(pin_n[6]), .lid_n_in(pin_n[7]), .sleep_button_n_in(pin_n[8]), .*);
   carrier_model #(.HOLD(12)) board (.clk_in(clk_in), .want_n_in(want_n), .pin_n_out(pin_n),
      .dev_oe_in({smbus_data_oe_out, smbus_clock_oe_out}), .car_low_in(car_low),
      .smb_out({smbus_data_in, smbus_clock_in}));
   always #5 clk_in = !clk_in;
   // tally pulses and reset cycles, cut a hang short
   always @(posedge clk_in) begin
      foreach (seen[k])
         if (ev[k] === 1'b1)
            seen[k]++;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wt(int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic chk(string n, logic s, logic e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL %s exp %b seen %b", n, e, s);
      end
   endtask
   task automatic done();
      $display("test end at cycle %0d", cyc);
   endtask
   // press with a random length, then let it settle
   task automatic press(int i);
      rnd = lfsr(rnd);
      want_n[i] <= 1'b0;
      wt(1 + rnd[3:0]);
      want_n[i] <= 1'b1;
      wt(30);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      wt(16);
      resetn_in <= 1'b1;
      wt(2);
      chk("off", soft_off_n_out, 0);
      chk("disk", disk_suspend_n_out, 1);
      press(0);
      chk("off", soft_off_n_out, 1);
      chk("run", system_running_out, 1);
      b = seen[5];
      want_n[1] <= 1'b0;
      wt(40);
      chk("rst", carrier_reset_n_out, 1);
      chk("rst_seen", seen[5] > b, 1);
      want_n[1] <= 1'b1;
      wt(30);
      done();
      for (int k = 0; k < 4; k++) begin
         b = seen[5];
         {primary_supply_low_in, watchdog_timeout_in, soft_reset_req_in, supply_good_in} <= pat[k];
         wt(k == 3 ? 20 : 1);
         {primary_supply_low_in, watchdog_timeout_in, soft_reset_req_in, supply_good_in} <= 4'h1;
         wt(30);
         chk("cause", seen[5] > b, 1);
         chk("rst", carrier_reset_n_out, 1);
      end
      done();
      for (int k = 0; k < 4; k++) begin
         b = seen[0] + seen[1];
         if (k == 0) begin
            press(8);
         end else begin
            suspend_req_in <= 1'b1;
            wt(1);
            suspend_req_in <= 1'b0;
            wt(20);
         end
         chk("ram", ram_suspend_n_out, 0);
         chk("pend", suspend_pending_n_out, 0);
         press(wk[k]);
         chk("ram", ram_suspend_n_out, 1);
         chk("wake", seen[0] + seen[1] > b, 1);
      end
      chk("sleep", seen[4] > 1, 1);
      b = seen[2];
      press(4);
      chk("bat", seen[2] > b, 1);
      b = seen[3];
      for (int k = 5; k < 8; k += 2) begin
         want_n[k] <= 1'b0;
         wt(30);
         chk("level", k == 5 ? overtemp_out : lid_closed_out, 1);
         want_n[k] <= 1'b1;
         wt(30);
         chk("level", k == 5 ? overtemp_out : lid_closed_out, 0);
      end
      chk("lid", seen[3] > b, 1);
      done();
      for (int k = 0; k < 2; k++) begin
         {cpu_shutdown_in, soft_off_req_in} <= k ? 2'b10 : 2'b01;
         wt(1);
         {cpu_shutdown_in, soft_off_req_in} <= 2'b00;
         wt(8);
         chk("off", soft_off_n_out, 0);
         chk("trip", cpu_trip_n_out, k == 0);
         press(0);
         chk("trip", cpu_trip_n_out, 1);
      end
      repeat (8) begin
         rnd = lfsr(rnd);
         {smbus_data_drive_low_in, smbus_clock_drive_low_in} <= rnd[1:0];
         car_low <= rnd[3:2];
         wt(4);
         chk("scl", smbus_clock_sense_out, !(rnd[0] | rnd[2]));
         chk("sda", smbus_data_sense_out, !(rnd[1] | rnd[3]));
         chk("scl_drv", smbus_clock_out, 0);
         chk("sda_drv", smbus_data_out, 0);
         chk("sda_oe", smbus_data_oe_out, rnd[1]);
      end
      done();
      report_and_stop();
   end
endmodule // power_state_manager_tb
`default_nettype wire
